// File: inc/emi_pkg.sv
// package: constants and types for the external memory strobe interface
package emi_pkg;
  localparam int unsigned ADDR_W      = 17;
  localparam int unsigned DATA_W      = 16;
  localparam logic [3:0]  STROBE_CYC  = 4'h0002;  // strobe low cycles per access
  localparam logic        BUS_DRV_RST = 1'b0;     // bus-drive bit after reset
  localparam logic        CS0_PS_RST  = 1'b1;     // chip select zero as program select after reset

  typedef enum logic [1:0] {
    EMI_IDLE  = 2'b00,
    EMI_SETUP = 2'b01,
    EMI_STRB  = 2'b11,
    EMI_HOLD  = 2'b10
  } emi_state_t;

  // one access request from the core
  typedef struct packed {
    logic                  wr;      // 1 write, 0 read
    logic                  prog;    // 1 program space, 0 data space
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
  } emi_req_t;

  // pin group of the external bus
  typedef struct packed {
    logic                  rd_n;
    logic                  rd_oe;
    logic                  wr_n;
    logic                  wr_oe;
    logic                  ps_n;
    logic                  ps_oe;
    logic                  ds_n;
    logic                  ds_oe;
    logic [ADDR_W-1:0]     addr;
    logic                  addr_oe;
    logic [DATA_W-1:0]     dout;
    logic                  d_oe;
  } emi_pins_t;
endpackage

// File: verilog/emi_strobe.sv
// module: external memory strobe generator with shared port line on the program select pin
module emi_strobe (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // control bits
  input  wire logic                     bus_drive_hold,
  input  wire logic                     port_d8_gpio_mode,
  input  wire logic                     port_d8_dir_out,
  input  wire logic                     port_d8_out_val,
  // core request and answer
  input  wire logic                     req_valid,
  input  wire emi_pkg::emi_req_t        req,
  output logic                          req_ready,
  output logic                          rdata_valid,
  output logic [emi_pkg::DATA_W-1:0]    rdata,
  output logic                          port_d8_in_val,
  // external bus
  output emi_pkg::emi_pins_t            pins,
  input  wire logic [emi_pkg::DATA_W-1:0] data_in,
  input  wire logic                     ps_pin_in
);
  import emi_pkg::*;

  emi_state_t               state_r, state_nxt;
  emi_req_t                 cur_r, cur_nxt;
  logic [3:0]               cnt_r, cnt_nxt;
  logic                     cs0_ps_r, cs0_ps_nxt;
  emi_pins_t                pins_nxt;
  logic                     rvalid_nxt;
  logic [DATA_W-1:0]        rdata_nxt;
  logic                     ready_nxt;
  logic                     active;

  // sequencer: setup, strobe low for STROBE_CYC cycles, hold with strobe high
  always_comb begin
    state_nxt  = state_r;
    cur_nxt    = cur_r;
    cnt_nxt    = cnt_r;
    cs0_ps_nxt = cs0_ps_r;
    rvalid_nxt = 1'b0;
    rdata_nxt  = rdata;
    unique case (state_r)
      EMI_IDLE: begin
        if (req_valid) begin
          cur_nxt   = req;
          state_nxt = EMI_SETUP;
        end
      end
      EMI_SETUP: begin
        cnt_nxt   = STROBE_CYC;
        state_nxt = EMI_STRB;
      end
      EMI_STRB: begin
        cnt_nxt = cnt_r - 4'h0001;
        if (cnt_r == 4'h0001) begin
          state_nxt = EMI_HOLD;
          if (!cur_r.wr) begin
            rdata_nxt  = data_in;
            rvalid_nxt = 1'b1;
          end
        end
      end
      EMI_HOLD: begin
        state_nxt = EMI_IDLE;
      end
    endcase
  end

  assign active = (state_nxt != EMI_IDLE);

  // pin drive for the next cycle
  always_comb begin
    pins_nxt         = '0;
    pins_nxt.addr    = cur_nxt.addr;
    pins_nxt.addr_oe = active | bus_drive_hold;
    pins_nxt.rd_n    = !(state_nxt == EMI_STRB && !cur_nxt.wr);
    pins_nxt.wr_n    = !(state_nxt == EMI_STRB && cur_nxt.wr);
    pins_nxt.rd_oe   = active | bus_drive_hold;
    pins_nxt.wr_oe   = active | bus_drive_hold;
    pins_nxt.ps_n    = !(active && cur_nxt.prog && cs0_ps_r);
    pins_nxt.ds_n    = !(active && !cur_nxt.prog);
    pins_nxt.ds_oe   = active | bus_drive_hold;
    pins_nxt.ps_oe   = active | bus_drive_hold;
    pins_nxt.dout    = cur_nxt.wdata;
    pins_nxt.d_oe    = active && cur_nxt.wr;
    if (port_d8_gpio_mode) begin
      pins_nxt.ps_n  = port_d8_out_val;
      pins_nxt.ps_oe = port_d8_dir_out;
    end
    ready_nxt = (state_nxt == EMI_IDLE) && !(state_r == EMI_IDLE && req_valid);
  end

  // register everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r        <= EMI_IDLE;
      cur_r          <= '0;
      cnt_r          <= 4'h0000;
      cs0_ps_r       <= CS0_PS_RST;
      pins           <= '{rd_n: 1'b1, wr_n: 1'b1, ps_n: 1'b1, ds_n: 1'b1, default: '0};
      rdata_valid    <= 1'b0;
      rdata          <= '0;
      req_ready      <= 1'b0;
      port_d8_in_val <= 1'b1;
    end else begin
      state_r        <= state_nxt;
      cur_r          <= cur_nxt;
      cnt_r          <= cnt_nxt;
      cs0_ps_r       <= cs0_ps_nxt;
      pins           <= pins_nxt;
      rdata_valid    <= rvalid_nxt;
      rdata          <= rdata_nxt;
      req_ready      <= ready_nxt;
      port_d8_in_val <= ps_pin_in;
    end
  end

  // strobes exclusive
  a_strobe_excl: assert property (@(posedge clk) disable iff (!rst_b)
    !(!pins.rd_n && !pins.wr_n))
    else $error("read and write strobes low together");

  // data direction during read
  a_read_dir: assert property (@(posedge clk) disable iff (!rst_b)
    !pins.rd_n |-> !pins.d_oe)
    else $error("data driven during read strobe");

  // data driven during write
  a_write_dir: assert property (@(posedge clk) disable iff (!rst_b)
    !pins.wr_n |-> pins.d_oe && pins.dout == cur_r.wdata)
    else $error("write data not driven");

  // address stable under read strobe
  a_rd_addr: assert property (@(posedge clk) disable iff (!rst_b)
    (!pins.rd_n && !$past(pins.rd_n)) |-> $stable(pins.addr) && pins.addr_oe)
    else $error("address moved");

  // address stable under write strobe
  a_wr_addr: assert property (@(posedge clk) disable iff (!rst_b)
    (!pins.wr_n && !$past(pins.wr_n)) |-> $stable(pins.addr) && $stable(pins.ds_n))
    else $error("write qualifiers moved");

  // read strobe low for exactly two cycles
  a_rd_len: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(pins.rd_n) |-> !pins.rd_n ##1 !pins.rd_n ##1 pins.rd_n)
    else $error("read strobe length wrong");

  // write strobe low for exactly two cycles
  a_wr_len: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(pins.wr_n) |-> !pins.wr_n ##1 !pins.wr_n ##1 pins.wr_n)
    else $error("write strobe length wrong");

  // read data captured at strobe release
  a_rd_capture: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pins.rd_n) |-> rdata_valid)
    else $error("read data not captured at strobe rise");

  // idle read strobe floats while the bus-drive bit is off
  a_idle_drive: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_IDLE && $past(state_r) == EMI_IDLE && $past(bus_drive_hold, 1) == 1'b0) |-> !pins.rd_oe)
    else $error("strobe driven while idle with hold off");

  // data select during data strobe
  a_ds_low: assert property (@(posedge clk) disable iff (!rst_b)
    (!pins.rd_n && !cur_r.prog) |-> !pins.ds_n && pins.ps_n)
    else $error("data select wrong");

  // program select during program strobe
  a_ps_low: assert property (@(posedge clk) disable iff (!rst_b)
    (!pins.rd_n && cur_r.prog && !port_d8_gpio_mode && !$past(port_d8_gpio_mode)) |-> !pins.ps_n)
    else $error("program select not low");

  // read strobe low in the strobe phase of a read
  a_rd_state: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_STRB && !cur_r.wr) |-> !pins.rd_n)
    else $error("read strobe missing in strobe phase");

  // read strobe low only in the strobe phase of a read
  a_rd_only: assert property (@(posedge clk) disable iff (!rst_b)
    !pins.rd_n |-> (state_r == EMI_STRB && !cur_r.wr))
    else $error("read strobe outside read strobe phase");

  // write strobe low in the strobe phase of a write
  a_wr_state: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_STRB && cur_r.wr) |-> !pins.wr_n)
    else $error("write strobe missing in strobe phase");

  // write strobe low only in the strobe phase of a write
  a_wr_only: assert property (@(posedge clk) disable iff (!rst_b)
    !pins.wr_n |-> (state_r == EMI_STRB && cur_r.wr))
    else $error("write strobe outside write strobe phase");

  // strobes stay high during setup so the address settles first
  a_setup_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_SETUP) |-> pins.rd_n && pins.wr_n)
    else $error("strobe low during setup");

  // strobes already high in the hold phase
  a_hold_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_HOLD) |-> pins.rd_n && pins.wr_n)
    else $error("strobe low during hold");

  // address kept and driven through the hold phase
  a_hold_addr: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_HOLD) |-> pins.addr == cur_r.addr && pins.addr_oe)
    else $error("address dropped in hold");

  // address follows the access for its whole length
  a_addr_cur: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r != EMI_IDLE) |-> pins.addr == cur_r.addr && pins.addr_oe)
    else $error("address not that of the access");

  // data pins driven only by a write access
  a_d_oe_active: assert property (@(posedge clk) disable iff (!rst_b)
    pins.d_oe |-> (state_r != EMI_IDLE && cur_r.wr))
    else $error("data driven outside a write");

  // data pins driven for the whole write access
  a_d_oe_write: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r != EMI_IDLE && cur_r.wr) |-> pins.d_oe)
    else $error("write data not driven during write");

  // idle bus leaves the data pins as inputs
  a_idle_no_data: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_IDLE) |-> !pins.d_oe)
    else $error("data driven while idle");

  // read answer only at the end of a read
  a_rvalid_read: assert property (@(posedge clk) disable iff (!rst_b)
    rdata_valid |-> (state_r == EMI_HOLD && !cur_r.wr))
    else $error("read answer outside read hold");

  // read answer is a one-cycle pulse
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    rdata_valid |=> !rdata_valid)
    else $error("read answer longer than one cycle");

  // read data is the bus level at the last strobe-low edge
  a_rdata_value: assert property (@(posedge clk) disable iff (!rst_b)
    rdata_valid |-> rdata == $past(data_in))
    else $error("read data not the bus level at strobe release");

  // read data holds between answers
  a_rdata_keep: assert property (@(posedge clk) disable iff (!rst_b)
    !rdata_valid |-> $stable(rdata))
    else $error("read data changed without an answer");

  // data select low means program select high
  a_ps_data_high: assert property (@(posedge clk) disable iff (!rst_b)
    (!pins.ds_n && !$past(port_d8_gpio_mode)) |-> pins.ps_n)
    else $error("both selects low");

  // program access keeps data select high
  a_ds_prog_high: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r != EMI_IDLE && cur_r.prog) |-> pins.ds_n)
    else $error("data select low on program access");

  // data access drives data select low throughout
  a_ds_data_low: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r != EMI_IDLE && !cur_r.prog) |-> !pins.ds_n)
    else $error("data select high on data access");

  // program access drives program select low throughout
  a_ps_prog_low: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r != EMI_IDLE && cur_r.prog && !$past(port_d8_gpio_mode)) |-> !pins.ps_n)
    else $error("program select high on program access");

  // selects high while the bus is idle
  a_idle_selects: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_IDLE && !$past(port_d8_gpio_mode)) |-> pins.ps_n && pins.ds_n)
    else $error("select low while idle");

  // port line mode drives the pin from the port bits
  a_gpio_ps_value: assert property (@(posedge clk) disable iff (!rst_b)
    $past(port_d8_gpio_mode) |-> pins.ps_n == $past(port_d8_out_val) && pins.ps_oe == $past(port_d8_dir_out))
    else $error("port line value or direction wrong");

  // port line input is the pin level one cycle late
  a_port_in: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> port_d8_in_val == $past(ps_pin_in))
    else $error("port line input not sampled");

  // no new request taken while an access holds the bus
  a_busy_ready: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r != EMI_IDLE) |-> !req_ready)
    else $error("ready while busy");

  // strobes and data select driven during an access
  a_active_oe: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r != EMI_IDLE) |-> pins.rd_oe && pins.wr_oe && pins.ds_oe)
    else $error("control pin floating during access");

  // idle with hold on keeps strobes and address driven
  a_idle_hold_on: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(rst_b) && state_r == EMI_IDLE && $past(bus_drive_hold)) |-> pins.rd_oe && pins.wr_oe && pins.addr_oe)
    else $error("idle pins floating with hold on");

  // idle with hold off floats write strobe, data select and address
  a_idle_hold_off: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_IDLE && !$past(bus_drive_hold)) |-> !pins.wr_oe && !pins.addr_oe && !pins.ds_oe)
    else $error("idle pins driven with hold off");

  // idle program select floats with hold off outside port mode
  a_ps_idle_off: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_IDLE && !$past(bus_drive_hold) && !$past(port_d8_gpio_mode)) |-> !pins.ps_oe)
    else $error("program select driven while idle with hold off");

  // strobe phase always follows setup
  a_setup_next: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == EMI_SETUP) |=> (state_r == EMI_STRB))
    else $error("setup not followed by strobe");

  // chip select zero keeps its program select role
  a_cs0_fixed: assert property (@(posedge clk) disable iff (!rst_b)
    cs0_ps_r == CS0_PS_RST)
    else $error("chip select zero lost program select role");
endmodule

// File: sim/emi_mem_model.sv
// behavioural static memory on the far side of the strobe bus
module emi_mem_model (
  // strobes and select
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        ps_n,
  // address and data
  input  wire logic [16:0] addr,
  input  wire logic [15:0] dout,
  output logic      [15:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [32];
  logic [15:0] last = 16'h0000;
  logic [4:0]  idx;
  assign idx = {~ps_n, addr[3:0]};
  // write data taken on the rising write strobe
  always @(posedge wr_n) mem[idx] <= dout;
  // released bus shows the inverse of the last word, never a stale copy
  always @(posedge rd_n) last = mem[idx];
  assign data = rd_n ? ~last : mem[idx];
endmodule

// File: sim/tb_top.sv
// testbench: strobe interface against a behavioural memory
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import emi_pkg::*;
  logic        clk = 0, rst_b = 0, hold = 0, gm = 0, gdir = 0, gval = 0, ext_ps = 1, req_valid = 0;
  emi_req_t    req = '0;
  emi_pins_t   pins;
  logic        req_ready, rdata_valid, in_val;
  logic [15:0] rdata, mem_d, data_in;
  int          err_count = 0, checked = 0;
  // data bus level: device when enabled, memory otherwise
  assign data_in = pins.d_oe ? pins.dout : mem_d;
  emi_strobe DUT (.clk(clk), .rst_b(rst_b), .bus_drive_hold(hold), .port_d8_gpio_mode(gm),
    .port_d8_dir_out(gdir), .port_d8_out_val(gval), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rdata_valid(rdata_valid), .rdata(rdata), .port_d8_in_val(in_val),
    .pins(pins), .data_in(data_in), .ps_pin_in(pins.ps_oe ? pins.ps_n : ext_ps));
  // floating strobes and select read high: pull-ups left on by software
  emi_mem_model MEM (.rd_n(pins.rd_oe ? pins.rd_n : 1'b1), .wr_n(pins.wr_oe ? pins.wr_n : 1'b1),
    .ps_n(pins.ps_oe ? pins.ps_n : 1'b1), .addr(pins.addr),
    .dout(pins.dout), .data(mem_d));
  // clock
  initial forever #2 clk = ~clk;
  task automatic check(input string nm, input logic [16:0] exp, input logic [16:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one access, checked mid-strobe and at the answer
  task automatic access(input logic w, input logic p, input logic [16:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        finish_test();
      end
      tick(1);
    end
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{w, p, a, d};
    @(posedge clk);
    req_valid <= 1'b0;
    tick(2);
    check("rd_n", w, pins.rd_n);
    check("wr_n", !w, pins.wr_n);
    check("d_oe", w, pins.d_oe);
    check("ps_n", !p, pins.ps_n);
    check("ds_n", p, pins.ds_n);
    check("addr", a, pins.addr);
    if (w) check("dout", d, pins.dout);
    tick(1);
    check("rd_n end", 1, pins.rd_n);
    if (!w) check("rdata_valid", 1, rdata_valid);
    if (!w) check("rdata", d, rdata);
  endtask
  // idle strobes float with hold off, stay driven with it on
  task automatic t_idle(input logic h);
    @(posedge clk);
    hold <= h;
    tick(3);
    check("idle rd_oe", h, pins.rd_oe);
    check("idle wr_oe", h, pins.wr_oe);
    check("idle rd_n", 1, pins.rd_n);
    check("idle addr_oe", h, pins.addr_oe);
    check("idle ds_oe", h, pins.ds_oe);
  endtask
  // back to back writes and reads in both spaces at one address
  task automatic t_rw;
    access(1, 0, 17'h1_0005, 16'ha5c3);
    access(1, 1, 17'h1_0005, 16'h3c5a);
    access(0, 0, 17'h1_0005, 16'ha5c3);
    access(0, 1, 17'h1_0005, 16'h3c5a);
  endtask
  // program select pin used as a port line, out then in
  task automatic t_gpio;
    @(posedge clk);
    gm <= 1'b1;
    gdir <= 1'b1;
    tick(3);
    check("gpio ps_oe", 1, pins.ps_oe);
    check("gpio ps_n", 0, pins.ps_n);
    @(posedge clk);
    gdir <= 1'b0;
    ext_ps <= 1'b0;
    tick(3);
    check("gpio in", 0, in_val);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    check("reset oe", 0, pins.rd_oe | pins.wr_oe | pins.ps_oe);
    t_idle(1);
    t_rw;
    t_idle(1);
    t_idle(0);
    t_gpio;
    finish_test();
  end
endmodule
